// >>> pch_pkg.sv
// Operation
// - Class code reads 02H, 80H, 00H
// - Read command chosen from size and cacheline
// - Cacheline size byte, read/write, resets zero
// - Latency count byte, read/write, resets zero
// - Header layout reads zero, top byte zero
// - Multi-function flag reads zero
// - Space indicator bit reads zero
// - Location type bits read 00B
// - Prefetchable flag reads zero
// - Base bits 12:4 always read zero
// - Base bits 31:13 writable, reset zero
// - All-ones write reads back size mask
// - Window decode stops when memory enable clear
// - Interrupt routing byte writable, resets zero
// - Interrupt pin byte reads 01H
// - Minimum grant byte reads 05H
// - Maximum latency byte reads 0FH
// - Memory cycles claimed only while enabled
// - Read-only writes ignored, writable bits reset zero
package pch_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] PCH_OFS_CLASS   = 8'h08;
  localparam logic [7:0] PCH_OFS_COMMAND = 8'h04;
  localparam logic [7:0] PCH_OFS_CLHDR   = 8'h0C;
  localparam logic [7:0] PCH_OFS_BASE    = 8'h10;
  localparam logic [7:0] PCH_OFS_IRQ     = 8'h3C;

  // ==========================================================================
  // Fixed field values
  localparam logic [7:0] PCH_BASE_CLASS  = 8'h02;
  localparam logic [7:0] PCH_SUB_CLASS   = 8'h80;
  localparam logic [7:0] PCH_PROG_IF     = 8'h00;
  localparam logic [6:0] PCH_HDR_LAYOUT  = 7'h00;
  localparam logic       PCH_MULTI_FUNC  = 1'b0;
  localparam logic [7:0] PCH_IRQ_PIN     = 8'h01;
  localparam logic [7:0] PCH_MIN_GRANT   = 8'h05;
  localparam logic [7:0] PCH_MAX_LAT     = 8'h0F;
  localparam logic [1:0] PCH_LOC_TYPE    = 2'h0;
  localparam logic       PCH_SPACE_IND   = 1'b0;
  localparam logic       PCH_PREFETCH    = 1'b0;

  // ==========================================================================
  // Field positions and reset values
  localparam int         PCH_BASE_LSB    = 13;
  localparam int         PCH_BASE_W      = 19;
  localparam int         PCH_MEMEN_BIT   = 1;
  localparam logic [7:0] PCH_BYTE_RST    = 8'h00;
  localparam logic [18:0] PCH_BASE_RST   = 19'h00000;

  // ==========================================================================
  // Read command encodings
  localparam logic [3:0] PCH_CMD_MR      = 4'h6;
  localparam logic [3:0] PCH_CMD_MRL     = 4'hE;
  localparam logic [3:0] PCH_CMD_MRM     = 4'hC;
  localparam logic [7:0] PCH_ONE_DWORD   = 8'h01;

  // Configuration access bundle
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  offset;
    logic [3:0]  byte_en;
    logic [31:0] wdata;
  } pch_cfg_req_t;

endpackage : pch_pkg

// >>> pch_read_cmd.sv
`timescale 1ns/1ps
// ============================================================================
// Master read command chooser
module pch_read_cmd
  import pch_pkg::*;
(
  // Request
  input  wire logic [7:0] size_in,
  input  wire logic [7:0] cacheline_words_in,
  // Result
  output logic [3:0]      cmd_out
);

  // Single dword, within a line, or longer than a line
  always_comb begin
    if (size_in == PCH_ONE_DWORD) begin
      cmd_out = PCH_CMD_MR;
    end else if (size_in <= cacheline_words_in) begin
      cmd_out = PCH_CMD_MRL;
    end else begin
      cmd_out = PCH_CMD_MRM;
    end
  end

endmodule : pch_read_cmd

// >>> pch_config_regs.sv
`timescale 1ns/1ps
// ============================================================================
// Configuration header registers, cacheline/latency, base and interrupt info
module pch_config_regs
  import pch_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  // Configuration access from the host bus controller
  input  wire pch_cfg_req_t cfg_in,
  output logic [31:0]       cfg_rdata_out,
  output logic              cfg_rvalid_out,
  // Target decoder side
  input  wire logic [31:0]  mem_addr_in,
  input  wire logic         mem_addr_valid_in,
  output logic              window_hit_out,
  output logic [18:0]       window_base_out,
  output logic              mem_space_enable_out,
  // Master read side
  input  wire logic [7:0]   read_size_in,
  output logic [3:0]        read_cmd_out,
  output logic [7:0]        cacheline_words_out
);

  // ==========================================================================
  // Storage
  logic [7:0]  cacheline_words;   // Line size in dwords
  logic [7:0]  latency_count;     // Latency timer in clocks
  logic [18:0] window_base_field; // Writable window base bits
  logic [7:0]  irq_route_byte;    // System routing, no effect inside
  logic        mem_space_enable;  // Command register memory enable
  logic [3:0]  next_cmd;          // Chosen read command

  // Write strobe helper, used by every register
  function automatic logic wr_hit(input pch_cfg_req_t r, input logic [7:0] ofs);
    wr_hit = r.wr && (r.offset == ofs);
  endfunction : wr_hit

  // ==========================================================================
  // Cacheline size and latency timer, byte by byte
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cacheline_words <= PCH_BYTE_RST;
      latency_count   <= PCH_BYTE_RST;
    end else if (wr_hit(cfg_in, PCH_OFS_CLHDR)) begin
      // Upper bytes are read-only, their write data is dropped
      if (cfg_in.byte_en[0]) begin
        cacheline_words <= cfg_in.wdata[7:0];
      end
      if (cfg_in.byte_en[1]) begin
        latency_count <= cfg_in.wdata[15:8];
      end
    end
  end

  // ==========================================================================
  // Window base; low 13 bits are not stored so sizing reads give 8K
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      window_base_field <= PCH_BASE_RST;
    end else if (wr_hit(cfg_in, PCH_OFS_BASE)) begin
      // Byte 1 holds only bits 15:13 of the base
      if (cfg_in.byte_en[1]) begin
        window_base_field[2:0] <= cfg_in.wdata[15:13];
      end
      if (cfg_in.byte_en[2]) begin
        window_base_field[10:3] <= cfg_in.wdata[23:16];
      end
      if (cfg_in.byte_en[3]) begin
        window_base_field[18:11] <= cfg_in.wdata[31:24];
      end
    end
  end

  // ==========================================================================
  // Interrupt routing byte
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      irq_route_byte <= PCH_BYTE_RST;
    end else if (wr_hit(cfg_in, PCH_OFS_IRQ) && cfg_in.byte_en[0]) begin
      irq_route_byte <= cfg_in.wdata[7:0];
    end
  end

  // ==========================================================================
  // Memory space enable of the command register; cleared at reset
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      mem_space_enable <= 1'b0;
    end else if (wr_hit(cfg_in, PCH_OFS_COMMAND) && cfg_in.byte_en[0]) begin
      mem_space_enable <= cfg_in.wdata[PCH_MEMEN_BIT];
    end
  end

  // ==========================================================================
  // Read data, registered one cycle after the request
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cfg_rdata_out  <= '0;
      cfg_rvalid_out <= 1'b0;
    end else begin
      cfg_rvalid_out <= cfg_in.rd;
      cfg_rdata_out  <= '0;
      if (cfg_in.rd) begin
        unique case (cfg_in.offset)
          PCH_OFS_CLASS: begin
            // Revision byte lives elsewhere, reads zero here
            cfg_rdata_out <= {PCH_BASE_CLASS, PCH_SUB_CLASS, PCH_PROG_IF, 8'h00};
          end
          PCH_OFS_COMMAND: begin
            cfg_rdata_out <= {30'h0, mem_space_enable, 1'b0};
          end
          PCH_OFS_CLHDR: begin
            cfg_rdata_out <= {8'h00, PCH_MULTI_FUNC, PCH_HDR_LAYOUT,
                              latency_count, cacheline_words};
          end
          PCH_OFS_BASE: begin
            cfg_rdata_out <= {window_base_field, 9'h000, PCH_PREFETCH,
                              PCH_LOC_TYPE, PCH_SPACE_IND};
          end
          PCH_OFS_IRQ: begin
            cfg_rdata_out <= {PCH_MAX_LAT, PCH_MIN_GRANT, PCH_IRQ_PIN,
                              irq_route_byte};
          end
          default: begin
            // Other offsets belong to neighbouring blocks
            cfg_rdata_out <= '0;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Window decode: claimed only while memory space is enabled
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      window_hit_out <= 1'b0;
    end else begin
      window_hit_out <= mem_addr_valid_in && mem_space_enable &&
        (mem_addr_in[31:PCH_BASE_LSB] == window_base_field);
    end
  end

  // ==========================================================================
  // Master read command
  pch_read_cmd u_read_cmd (
    .size_in            (read_size_in),
    .cacheline_words_in (cacheline_words),
    .cmd_out            (next_cmd)
  );

  // Registered command for the master
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      read_cmd_out <= PCH_CMD_MR;
    end else begin
      read_cmd_out <= next_cmd;
    end
  end

  // Exported configuration values
  assign window_base_out      = window_base_field;
  assign mem_space_enable_out = mem_space_enable;
  assign cacheline_words_out  = cacheline_words;

endmodule : pch_config_regs

// >>> pch_asserts.sv
`timescale 1ns/1ps
// ======
// Port checker for the configuration header registers
module pch_asserts
  import pch_pkg::*;
(
  // Clock and reset
  input wire logic         clk_in,
  input wire logic         rst_n_in,
  // Configuration side
  input wire pch_cfg_req_t cfg_in,
  input wire logic [31:0]  cfg_rdata_out,
  input wire logic         cfg_rvalid_out,
  // Decoder and master side
  input wire logic [31:0]  mem_addr_in,
  input wire logic         mem_addr_valid_in,
  input wire logic         window_hit_out,
  input wire logic [18:0]  window_base_out,
  input wire logic         mem_space_enable_out,
  input wire logic [7:0]   read_size_in,
  input wire logic [3:0]   read_cmd_out,
  input wire logic [7:0]   cacheline_words_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Reads of the class, header, base and interrupt offsets, and a claimable address
  wire rd_cls  = cfg_in.rd && cfg_in.offset == 8'h08;
  wire rd_hdr  = cfg_in.rd && cfg_in.offset == 8'h0C;
  wire rd_base = cfg_in.rd && cfg_in.offset == 8'h10;
  wire rd_irq  = cfg_in.rd && cfg_in.offset == 8'h3C;
  wire claim   = mem_addr_valid_in && mem_space_enable_out && mem_addr_in[31:13] == window_base_out;
  // ======
  // Read data checks
  property p_class; rd_cls |=> cfg_rvalid_out && cfg_rdata_out[31:8] == 24'h028000; endproperty
  a_class: assert property (p_class) else $error("class code read wrong");
  property p_hdr; rd_hdr |=> cfg_rdata_out[31:16] == 16'h0000 && cfg_rdata_out[7:0] == $past(cacheline_words_out); endproperty
  a_hdr: assert property (p_hdr) else $error("header dword read wrong");
  property p_base; rd_base |=> cfg_rdata_out == {$past(window_base_out), 13'h0000}; endproperty
  a_base: assert property (p_base) else $error("base read wrong");
  property p_irq; rd_irq |=> cfg_rdata_out[31:8] == 24'h0F0501; endproperty
  a_irq: assert property (p_irq) else $error("interrupt info read wrong");
  // ======
  // Command choice, decode and reset
  property p_cmd;
    1'b1 |=> read_cmd_out == (($past(read_size_in) == 8'h01) ? 4'h6 :
      ($past(read_size_in) <= $past(cacheline_words_out)) ? 4'hE : 4'hC);
  endproperty
  a_cmd: assert property (p_cmd) else $error("read command wrong");
  property p_hit; claim |=> window_hit_out; endproperty
  a_hit: assert property (p_hit) else $error("window not claimed");
  property p_nohit; !claim |=> !window_hit_out; endproperty
  a_nohit: assert property (p_nohit) else $error("window claimed wrongly");
  property p_rst; $rose(rst_n_in) |-> cacheline_words_out == 8'h00 && window_base_out == 19'h0 && !mem_space_enable_out;
  endproperty
  a_rst: assert property (p_rst) else $error("writable bits not cleared");
  // Main scenarios reached
  c_hit: cover property (window_hit_out);
  c_mrm: cover property (read_cmd_out == 4'hC);
  c_base: cover property (rd_base);
endmodule : pch_asserts

bind pch_config_regs pch_asserts i_pch_asserts (.clk_in, .rst_n_in, .cfg_in, .cfg_rdata_out, .cfg_rvalid_out,
  .mem_addr_in, .mem_addr_valid_in, .window_hit_out, .window_base_out, .mem_space_enable_out, .read_size_in,
  .read_cmd_out, .cacheline_words_out);

// >>> pch_host_model.sv
`timescale 1ns/1ps
// ======
// Host issuing configuration cycles, one per clock at most
module pch_host_model
  import pch_pkg::*;
(
  input  wire logic   clk_in,
  output pch_cfg_req_t cfg_out
);
  initial cfg_out = '0;
  // Request set after a falling edge, held through the taking edge
  task issue(input logic r, input logic w, input logic [7:0] o, input logic [3:0] b, input logic [31:0] d);
    @(negedge clk_in);
    cfg_out = '{r, w, o, b, d};
  endtask : issue
  // Released lines flip so stale data never passes for a request
  task idle();
    @(negedge clk_in);
    cfg_out = '{1'b0, 1'b0, ~cfg_out.offset, ~cfg_out.byte_en, ~cfg_out.wdata};
  endtask : idle
endmodule : pch_host_model

// >>> tb.sv
`timescale 1ns/1ps
// ======
// Self-checking bench for the configuration header registers
module tb;
  import pch_pkg::*;
  logic         clk_in = 1'b0;
  logic         rst_n_in = 1'b0;
  pch_cfg_req_t cfg_in;
  logic [31:0]  cfg_rdata_out, mem_addr_in = 32'h0;
  logic         cfg_rvalid_out, window_hit_out, mem_space_enable_out, mem_addr_valid_in = 1'b0;
  logic [18:0]  window_base_out;
  logic [7:0]   cacheline_words_out, read_size_in = 8'h01;
  logic [3:0]   read_cmd_out;
  int           bad_count = 0;
  int           comparisons = 0;
  always #50 clk_in = ~clk_in;
  pch_host_model i_pch_host_model (.clk_in, .cfg_out(cfg_in));
  pch_config_regs i_pch_config_regs (.clk_in, .rst_n_in, .cfg_in, .cfg_rdata_out, .cfg_rvalid_out, .mem_addr_in,
    .mem_addr_valid_in, .window_hit_out, .window_base_out, .mem_space_enable_out, .read_size_in, .read_cmd_out,
    .cacheline_words_out);
  // ======
  // Shared helpers
  task chk(input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task rd(input logic [7:0] o, input logic [31:0] exp);
    i_pch_host_model.issue(1'b1, 1'b0, o, 4'hF, 32'h0);
    i_pch_host_model.idle();
    chk(32'h1, {31'h0, cfg_rvalid_out});
    chk(exp, cfg_rdata_out);
  endtask : rd
  task wr(input logic [7:0] o, input logic [3:0] b, input logic [31:0] d);
    i_pch_host_model.issue(1'b0, 1'b1, o, b, d);
    i_pch_host_model.idle();
  endtask : wr
  // Present an address for one cycle, hit shows one cycle later
  task dec(input logic [31:0] a, input logic e);
    @(negedge clk_in);
    mem_addr_in = a;
    mem_addr_valid_in = 1'b1;
    @(negedge clk_in);
    mem_addr_valid_in = 1'b0;
    chk({31'h0, e}, {31'h0, window_hit_out});
  endtask : dec
  task tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  // ======
  // Scenarios
  task t_regs();
    rd(8'h08, 32'h0280_0000);
    rd(8'h3C, 32'h0F05_0100);
    rd(8'h20, 32'h0);
    wr(8'h0C, 4'hF, 32'hFFFF_FFFF);
    wr(8'h10, 4'hF, 32'hFFFF_FFFF);
    wr(8'h3C, 4'hF, 32'hFFFF_FFFF);
    rd(8'h0C, 32'h0000_FFFF);
    rd(8'h10, 32'hFFFF_E000);
    rd(8'h3C, 32'h0F05_01FF);
    wr(8'h0C, 4'h1, 32'h1234_5678);
    wr(8'h10, 4'h8, 32'h0);
    rd(8'h0C, 32'h0000_FF78);
    rd(8'h10, 32'h00FF_E000);
    chk({13'h0, 19'h007FF}, {13'h0, window_base_out});
    $display("test registers done");
  endtask : t_regs
  task t_cmd();
    logic [7:0] sz [4];
    logic [3:0] ex [4];
    sz = '{8'h01, 8'h08, 8'h09, 8'h00};
    ex = '{4'h6, 4'hE, 4'hC, 4'hE};
    wr(8'h0C, 4'h1, 32'h08);
    chk({24'h0, 8'h08}, {24'h0, cacheline_words_out});
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_in);
      read_size_in = sz[i];
      @(negedge clk_in);
      chk({28'h0, ex[i]}, {28'h0, read_cmd_out});
    end
    $display("test command done");
  endtask : t_cmd
  task t_decode();
    dec(32'h00FF_E004, 1'b0);
    chk(32'h0, {31'h0, mem_space_enable_out});
    wr(8'h04, 4'h1, 32'h2);
    chk(32'h1, {31'h0, mem_space_enable_out});
    dec(32'h00FF_E004, 1'b1);
    dec(32'h0100_0000, 1'b0);
    wr(8'h04, 4'h1, 32'h0);
    dec(32'h00FF_FFFC, 1'b0);
    $display("test decode done");
  endtask : t_decode
  // Reset in mid-run clears the base and the cacheline and latency bytes
  task t_reset();
    @(negedge clk_in);
    rst_n_in = 1'b0;
    repeat (2) @(negedge clk_in);
    rst_n_in = 1'b1;
    rd(8'h10, 32'h0);
    rd(8'h0C, 32'h0);
    chk(32'h0, {24'h0, cacheline_words_out});
    $display("test reset done");
  endtask : t_reset
  initial begin
    repeat (3) @(negedge clk_in);
    rst_n_in = 1'b1;
    t_regs();
    t_cmd();
    t_decode();
    t_reset();
    tally_and_finish();
  end
  // Tests need about 60 cycles
  initial begin
    repeat (1000) @(posedge clk_in);
    bad_count++;
    tally_and_finish();
  end
endmodule : tb
